// [common/lbl_map.vh]
// Register offsets, field positions and timing constants of the bias and pin control block.
`ifndef LBL_MAP_VH
`define LBL_MAP_VH
`define LBL_OFS_CTRL 4'h0
`define LBL_OFS_REF 4'h1
`define LBL_OFS_LADDER 4'h2
`define LBL_OFS_CST 4'h3
`define LBL_OFS_SEG0 4'h4
`define LBL_OFS_SEG1 4'h5
`define LBL_OFS_SEG2 4'h6
`define LBL_OFS_STATUS 4'h7
`define LBL_OFS_DIR 4'h8
`define LBL_CTRL_WFT 7
`define LBL_CTRL_HALF 6
`define LBL_CTRL_EN 5
`define LBL_CTRL_MUX_HI 1
`define LBL_CTRL_MUX_LO 0
`define LBL_REF_IRE 7
`define LBL_REF_IRS 6
`define LBL_REF_IRI 5
`define LBL_REF_PE_HI 3
`define LBL_REF_PE_LO 1
`define LBL_LAD_AP_HI 7
`define LBL_LAD_AP_LO 6
`define LBL_LAD_BP_HI 5
`define LBL_LAD_BP_LO 4
`define LBL_LAD_AT_HI 2
`define LBL_LAD_AT_LO 0
`define LBL_PWR_OFF 2'h0
`define LBL_MUX_STATIC 2'h0
`define LBL_MUX_HALF 2'h1
`define LBL_MUX_THIRD 2'h2
`define LBL_SLOT_A 5'h0F
`define LBL_SLOT_B 5'h1F
`define LBL_ZERO8 8'h00
`define LBL_ZERO24 24'h00_0000
`define LBL_ONES24 24'hFF_FFFF
`define LBL_ONE5 5'h01
`endif

// [core/lbl_bias_ctrl.v]
// Bias ladder power switching, reference gating and LCD pin configuration with an Avalon-MM slave.
// Function
// - Static, half and third bias types supported.
// - Half bias shorts middle ladder resistor.
// - Ladder low, medium, high or off.
// - Inactive driver forces ladder off.
// - Mode A after transition, then mode B.
// - Interval timed by 5-bit 32 kHz prescaler.
// - A lasts N clocks; slot 16 or 32.
// - Idle enable drops reference buffer in B when fed by fixed reference.
// - Reference from supply or 3x fixed reference.
// - Inactive driver turns internal reference off.
// - Inactive driver opens contrast ladder.
// - Contrast field selects one of eight taps.
// - Fixed reference enabled automatically when needed.
// - Each external bias pin has own enable.
// - Multiplex field selects active commons.
// - Active common pins override direction bits.
// - Segment enable overrides direction bit.
// - Reset leaves segment pins as I/O.
// - Driver-active status reads running state.
// - Waveform bit selects type B or A.
`timescale 1ns/1ns
`include "lbl_map.vh"
module lbl_bias_ctrl (
    input wire CLK_I,
    input wire RST_N_I,
    input wire [3:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output reg [31:0] AVS_READDATA_O,
    output reg AVS_WAITREQUEST_O,
    input wire TICK32K_I,
    input wire DRIVER_RUNNING_I,
    output reg LADDER_IN_A_O,
    output reg [1:0] LADDER_POWER_O,
    output reg LADDER_MID_SHORT_O,
    output reg [1:0] BIAS_TYPE_O,
    output reg INTERNAL_REF_ON_O,
    output reg REF_FROM_FVR_O,
    output reg REF_BUFFER_ON_O,
    output reg FVR_REQUEST_O,
    output reg CONTRAST_LADDER_ON_O,
    output reg [2:0] CONTRAST_TAP_O,
    output reg [2:0] EXTERNAL_BIAS_PINS_EN_O,
    output reg [3:0] COM_ACTIVE_O,
    output reg [3:0] COM_PIN_OE_N_O,
    output reg [23:0] SEG_DRIVE_O,
    output reg [23:0] SEG_PIN_OE_N_O
);
    reg [7:0] lcd_main_control;
    reg [7:0] bias_reference_control;
    reg [7:0] bias_ladder_power_timing;
    reg [2:0] contrast_tap_select;
    reg [23:0] segment_pin_enables;
    reg [27:0] port_direction_bits;
    reg tick_meta;
    reg tick_sync;
    reg tick_prev;
    reg run_meta;
    reg run_sync;
    reg [4:0] slot_count;
    reg ack;
    wire tick_rise;
    wire driver_active_status;
    wire waveform_type_select;
    wire half_bias_select;
    wire [1:0] common_multiplex_select;
    wire internal_ref_enable;
    wire ref_buffer_idle_enable;
    wire [1:0] ladder_power_interval_a;
    wire [1:0] ladder_power_interval_b;
    wire [2:0] interval_a_length;
    wire [4:0] slot_last;
    wire in_a;
    wire [3:0] com_used;
    wire [1:0] next_power;
    wire [1:0] next_bias;
    wire access;
    // Next values of the derived outputs, kept apart so each output register stays simple.
    wire ref_from_fvr;
    wire next_ref_on;
    wire next_buffer_on;
    wire next_fvr_request;
    wire [3:0] next_com_oe_n;
    wire [23:0] next_seg_oe_n;
    reg [31:0] next_readdata;

    function [7:0] merge;
        input [7:0] old;
        input [7:0] data;
        input be;
        begin
            merge = be ? data : old;
        end
    endfunction

    function [3:0] com_decode;
        input [1:0] mux;
        begin
            case (mux)
                `LBL_MUX_STATIC: com_decode = 4'h1;
                `LBL_MUX_HALF: com_decode = 4'h3;
                `LBL_MUX_THIRD: com_decode = 4'h7;
                default: com_decode = 4'hF;
            endcase
        end
    endfunction

    assign waveform_type_select = lcd_main_control[`LBL_CTRL_WFT];
    assign half_bias_select = lcd_main_control[`LBL_CTRL_HALF];
    assign common_multiplex_select = lcd_main_control[`LBL_CTRL_MUX_HI:`LBL_CTRL_MUX_LO];
    assign internal_ref_enable = bias_reference_control[`LBL_REF_IRE];
    assign ref_buffer_idle_enable = bias_reference_control[`LBL_REF_IRI];
    assign ladder_power_interval_a = bias_ladder_power_timing[`LBL_LAD_AP_HI:`LBL_LAD_AP_LO];
    assign ladder_power_interval_b = bias_ladder_power_timing[`LBL_LAD_BP_HI:`LBL_LAD_BP_LO];
    assign interval_a_length = bias_ladder_power_timing[`LBL_LAD_AT_HI:`LBL_LAD_AT_LO];
    // The running level arrives from the frame logic on another clock, so it is synchronised.
    assign driver_active_status = run_sync;
    assign tick_rise = tick_sync & ~tick_prev;
    assign slot_last = waveform_type_select ? `LBL_SLOT_B : `LBL_SLOT_A;
    assign in_a = slot_count < {2'b00, interval_a_length};
    assign next_power = !driver_active_status ? `LBL_PWR_OFF :
        (in_a ? ladder_power_interval_a : ladder_power_interval_b);
    // Static drive uses two levels, half three and third four.
    assign next_bias = (common_multiplex_select == `LBL_MUX_STATIC) ? 2'd0 :
        (half_bias_select ? 2'd1 : 2'd2);
    assign com_used = com_decode(common_multiplex_select);
    assign access = (AVS_READ_I | AVS_WRITE_I) & ~ack;
    assign ref_from_fvr = bias_reference_control[`LBL_REF_IRS];
    assign next_ref_on = internal_ref_enable & driver_active_status;
    // Dropping the buffer in mode B saves power, but only when the fixed reference feeds it.
    assign next_buffer_on = next_ref_on & ~(ref_from_fvr & ref_buffer_idle_enable & ~in_a);
    assign next_fvr_request = next_ref_on & ref_from_fvr;
    // A pin in use as a common or segment is driven whatever its direction bit says.
    assign next_com_oe_n = ~com_used & port_direction_bits[27:24];
    assign next_seg_oe_n = ~segment_pin_enables & port_direction_bits[23:0];

    // Read data is chosen combinationally and captured only when the access is taken.
    always @* begin
        next_readdata = 32'h0000_0000;
        case (AVS_ADDRESS_I)
            `LBL_OFS_CTRL: next_readdata = {24'h00_0000, lcd_main_control[7:6],
                driver_active_status, lcd_main_control[4:0]};
            `LBL_OFS_REF: next_readdata = {24'h00_0000, bias_reference_control};
            `LBL_OFS_LADDER: next_readdata = {24'h00_0000, bias_ladder_power_timing};
            `LBL_OFS_CST: next_readdata = {29'h0000_0000, contrast_tap_select};
            `LBL_OFS_SEG0: next_readdata = {24'h00_0000, segment_pin_enables[7:0]};
            `LBL_OFS_SEG1: next_readdata = {24'h00_0000, segment_pin_enables[15:8]};
            `LBL_OFS_SEG2: next_readdata = {24'h00_0000, segment_pin_enables[23:16]};
            `LBL_OFS_STATUS: next_readdata = {24'h00_0000, in_a, 2'b00, slot_count};
            `LBL_OFS_DIR: next_readdata = {4'h0, port_direction_bits};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
            run_meta <= 1'b0;
            run_sync <= 1'b0;
        end else begin
            tick_meta <= TICK32K_I;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
            run_meta <= DRIVER_RUNNING_I;
            run_sync <= run_meta;
        end
    end

    // The slot counter is the 5-bit prescaler; its wrap marks a segment or common transition.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            slot_count <= 5'h00;
        end else if (!driver_active_status) begin
            slot_count <= 5'h00;
        end else if (tick_rise) begin
            if (slot_count >= slot_last) begin
                slot_count <= 5'h00;
            end else begin
                slot_count <= slot_count + `LBL_ONE5;
            end
        end
    end

    // Every access takes one wait cycle, so the answer always comes at the second edge.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack <= 1'b0;
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O <= 32'h0000_0000;
        end else begin
            ack <= access;
            AVS_WAITREQUEST_O <= ~access;
            if (access && AVS_READ_I) begin
                AVS_READDATA_O <= next_readdata;
            end
        end
    end

    // Writes land at the edge that takes the access; unmapped offsets are ignored.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lcd_main_control <= `LBL_ZERO8;
            bias_reference_control <= `LBL_ZERO8;
            bias_ladder_power_timing <= `LBL_ZERO8;
            contrast_tap_select <= 3'h0;
            segment_pin_enables <= `LBL_ZERO24;
            port_direction_bits <= 28'hFFF_FFFF;
        end else begin
            if (access && AVS_WRITE_I) begin
                case (AVS_ADDRESS_I)
                    `LBL_OFS_CTRL: lcd_main_control <= merge(lcd_main_control,
                        AVS_WRITEDATA_I[7:0] & 8'hE3, AVS_BYTEENABLE_I[0]);
                    `LBL_OFS_REF: bias_reference_control <= merge(bias_reference_control,
                        AVS_WRITEDATA_I[7:0] & 8'hEE, AVS_BYTEENABLE_I[0]);
                    `LBL_OFS_LADDER: bias_ladder_power_timing <= merge(bias_ladder_power_timing,
                        AVS_WRITEDATA_I[7:0] & 8'hF7, AVS_BYTEENABLE_I[0]);
                    `LBL_OFS_CST: begin
                        if (AVS_BYTEENABLE_I[0]) begin
                            contrast_tap_select <= AVS_WRITEDATA_I[2:0];
                        end
                    end
                    `LBL_OFS_SEG0: segment_pin_enables[7:0] <= merge(segment_pin_enables[7:0],
                        AVS_WRITEDATA_I[7:0], AVS_BYTEENABLE_I[0]);
                    `LBL_OFS_SEG1: segment_pin_enables[15:8] <= merge(segment_pin_enables[15:8],
                        AVS_WRITEDATA_I[7:0], AVS_BYTEENABLE_I[0]);
                    `LBL_OFS_SEG2: segment_pin_enables[23:16] <= merge(
                        segment_pin_enables[23:16], AVS_WRITEDATA_I[7:0], AVS_BYTEENABLE_I[0]);
                    `LBL_OFS_DIR: begin
                        if (AVS_BYTEENABLE_I[0]) begin
                            port_direction_bits[7:0] <= AVS_WRITEDATA_I[7:0];
                        end
                        if (AVS_BYTEENABLE_I[1]) begin
                            port_direction_bits[15:8] <= AVS_WRITEDATA_I[15:8];
                        end
                        if (AVS_BYTEENABLE_I[2]) begin
                            port_direction_bits[23:16] <= AVS_WRITEDATA_I[23:16];
                        end
                        if (AVS_BYTEENABLE_I[3]) begin
                            port_direction_bits[27:24] <= AVS_WRITEDATA_I[27:24];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Outputs are registered; the analog side sees at most one clock of lag.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LADDER_IN_A_O <= 1'b0;
            LADDER_POWER_O <= `LBL_PWR_OFF;
        end else begin
            LADDER_IN_A_O <= driver_active_status & in_a;
            LADDER_POWER_O <= next_power;
        end
    end

    // The middle resistor is shorted whenever the half bias bit is set, even with static drive.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LADDER_MID_SHORT_O <= 1'b0;
            BIAS_TYPE_O <= 2'd0;
        end else begin
            LADDER_MID_SHORT_O <= half_bias_select;
            BIAS_TYPE_O <= next_bias;
        end
    end

    // The internal reference is never on while the driver is idle.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INTERNAL_REF_ON_O <= 1'b0;
            REF_FROM_FVR_O <= 1'b0;
        end else begin
            INTERNAL_REF_ON_O <= next_ref_on;
            REF_FROM_FVR_O <= ref_from_fvr;
        end
    end

    // Software never asks for the fixed reference; the request follows the configuration.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REF_BUFFER_ON_O <= 1'b0;
            FVR_REQUEST_O <= 1'b0;
        end else begin
            REF_BUFFER_ON_O <= next_buffer_on;
            FVR_REQUEST_O <= next_fvr_request;
        end
    end

    // Without an internal reference the contrast ladder is left open.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CONTRAST_LADDER_ON_O <= 1'b0;
            CONTRAST_TAP_O <= 3'h0;
        end else begin
            CONTRAST_LADDER_ON_O <= next_ref_on;
            CONTRAST_TAP_O <= contrast_tap_select;
        end
    end

    // External bias pins may be joined to the nodes while the ladder keeps running.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            EXTERNAL_BIAS_PINS_EN_O <= 3'h0;
        end else begin
            EXTERNAL_BIAS_PINS_EN_O <= bias_reference_control[`LBL_REF_PE_HI:`LBL_REF_PE_LO];
        end
    end

    // Commons stay undriven during reset so no pin fights the board.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            COM_ACTIVE_O <= 4'h0;
            COM_PIN_OE_N_O <= 4'hF;
        end else begin
            COM_ACTIVE_O <= com_used;
            COM_PIN_OE_N_O <= next_com_oe_n;
        end
    end

    // Segment pins are plain inputs during and after reset until software enables them.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SEG_DRIVE_O <= `LBL_ZERO24;
            SEG_PIN_OE_N_O <= `LBL_ONES24;
        end else begin
            SEG_DRIVE_O <= segment_pin_enables;
            SEG_PIN_OE_N_O <= next_seg_oe_n;
        end
    end
endmodule

// [verification/lbl_bias_ctrl_chk.sv]
// Port checker of the bias and pin control block.
`timescale 1ns/1ns
module lbl_chk (
    input wire CLK_I,
    input wire RST_N_I,
    input wire DRIVER_RUNNING_I,
    input wire LADDER_IN_A_O,
    input wire [1:0] LADDER_POWER_O,
    input wire LADDER_MID_SHORT_O,
    input wire [1:0] BIAS_TYPE_O,
    input wire INTERNAL_REF_ON_O,
    input wire REF_FROM_FVR_O,
    input wire FVR_REQUEST_O,
    input wire CONTRAST_LADDER_ON_O,
    input wire [3:0] COM_ACTIVE_O,
    input wire [3:0] COM_PIN_OE_N_O,
    input wire [23:0] SEG_DRIVE_O,
    input wire [23:0] SEG_PIN_OE_N_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // Six cycles cover the input synchroniser and the output register.
    sequence idle_s;
        !DRIVER_RUNNING_I [*6];
    endsequence
    ladder_off_a: assert property (idle_s |-> LADDER_POWER_O == 2'h0)
        else $error("ladder powered while driver idle");
    ref_off_a: assert property (idle_s |-> !INTERNAL_REF_ON_O)
        else $error("reference on while driver idle");
    mode_a_idle_a: assert property (idle_s |-> !LADDER_IN_A_O)
        else $error("mode A while driver idle");
    contrast_open_a: assert property (!INTERNAL_REF_ON_O |-> !CONTRAST_LADDER_ON_O)
        else $error("contrast ladder on without reference");
    fvr_auto_a: assert property (FVR_REQUEST_O == (INTERNAL_REF_ON_O && REF_FROM_FVR_O))
        else $error("fixed reference request wrong");
    com_drive_a: assert property ((COM_PIN_OE_N_O & COM_ACTIVE_O) == 4'h0)
        else $error("active common not driven");
    seg_drive_a: assert property ((SEG_PIN_OE_N_O & SEG_DRIVE_O) == 24'h00_0000)
        else $error("segment pin not driven");
    half_short_a: assert property (BIAS_TYPE_O == 2'h1 |-> LADDER_MID_SHORT_O)
        else $error("half bias without middle short");
endmodule
bind lbl_bias_ctrl lbl_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .DRIVER_RUNNING_I(DRIVER_RUNNING_I), .LADDER_IN_A_O(LADDER_IN_A_O),
    .LADDER_POWER_O(LADDER_POWER_O), .LADDER_MID_SHORT_O(LADDER_MID_SHORT_O),
    .BIAS_TYPE_O(BIAS_TYPE_O), .INTERNAL_REF_ON_O(INTERNAL_REF_ON_O),
    .REF_FROM_FVR_O(REF_FROM_FVR_O), .FVR_REQUEST_O(FVR_REQUEST_O),
    .CONTRAST_LADDER_ON_O(CONTRAST_LADDER_ON_O), .COM_ACTIVE_O(COM_ACTIVE_O),
    .COM_PIN_OE_N_O(COM_PIN_OE_N_O), .SEG_DRIVE_O(SEG_DRIVE_O),
    .SEG_PIN_OE_N_O(SEG_PIN_OE_N_O));

// [verification/lbl_glass_model.sv]
// Far-side model that supplies the free-running low-rate clock.
`timescale 1ns/1ns
module lbl_glass_model #(parameter int HALF_NS = 15000) (
    output logic tick_o
);
    // The odd start offset keeps this clock out of phase with the core clock.
    initial begin
        tick_o = 1'b0;
        #37;
        forever #(HALF_NS) tick_o = ~tick_o;
    end
endmodule

// [verification/lbl_bias_ctrl_tb_top.sv]
// Self-checking bench of the bias and pin control block.
`timescale 1ns/1ns
`include "lbl_map.vh"
`define LBL_CMP(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module lbl_bias_ctrl_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic run = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] v;
    logic [31:0] exp_v;
    logic [31:0] expq[$];
    logic [3:0] comt [4] = '{4'h1, 4'h3, 4'h7, 4'hF};
    wire [31:0] rdat;
    wire wait_r, tick, in_a, mid, ref_on, fvr_src, buf_on, fvr_req, cst_on;
    wire [1:0] pwr, btype;
    wire [2:0] tap, vpin;
    wire [3:0] com_act, com_oe_n;
    wire [23:0] seg, seg_oe_n;
    int checks = 0;
    int miscompares = 0;
    int seed = 32'h1e84_f7c0;
    lbl_glass_model u_glass (.tick_o(tick));
    lbl_bias_ctrl u_dut (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_r), .TICK32K_I(tick),
        .DRIVER_RUNNING_I(run), .LADDER_IN_A_O(in_a), .LADDER_POWER_O(pwr),
        .LADDER_MID_SHORT_O(mid), .BIAS_TYPE_O(btype), .INTERNAL_REF_ON_O(ref_on),
        .REF_FROM_FVR_O(fvr_src), .REF_BUFFER_ON_O(buf_on), .FVR_REQUEST_O(fvr_req),
        .CONTRAST_LADDER_ON_O(cst_on), .CONTRAST_TAP_O(tap), .EXTERNAL_BIAS_PINS_EN_O(vpin),
        .COM_ACTIVE_O(com_act), .COM_PIN_OE_N_O(com_oe_n), .SEG_DRIVE_O(seg),
        .SEG_PIN_OE_N_O(seg_oe_n));
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        if (rd && wait_r === 1'b0) begin
            exp_v = expq.pop_front();
            `LBL_CMP(rdat, exp_v)
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        @(posedge clk iff wait_r === 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_exp(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic settle;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
    // The count of mode A samples over two frames shows the interval length.
    task automatic ab_run(input int at, input int slot);
        int na;
        na = 0;
        bus(1'b1, `LBL_OFS_LADDER, 32'h0000_00D0 | at);
        repeat (slot) @(negedge tick);
        for (int i = 0; i < 2 * slot; i++) begin
            @(negedge tick);
            @(negedge clk);
            na += in_a;
            `LBL_CMP(pwr, in_a ? 2'h3 : 2'h1)
            `LBL_CMP(buf_on, in_a)
        end
        @(posedge clk);
        `LBL_CMP(na, 2 * at)
        $display("interval test %0d of %0d done", at, slot);
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #8_000_000;
        miscompares++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge clk);
        `LBL_CMP(seg_oe_n, 24'hFF_FFFF)
        rst_n <= 1'b1;
        settle;
        `LBL_CMP(seg_oe_n, 24'hFF_FFFF)
        @(posedge clk);
        rd_exp(`LBL_OFS_DIR, 32'h0FFF_FFFF);
        rd_exp(4'hC, 32'h0000_0000);
        $display("reset test done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `LBL_OFS_CTRL, 32'h0000_0040 | m);
            settle;
            `LBL_CMP(com_act, comt[m])
            `LBL_CMP(com_oe_n, ~comt[m])
            `LBL_CMP(btype, (m == 0) ? 2'h0 : 2'h1)
            @(posedge clk);
            rd_exp(`LBL_OFS_CTRL, 32'h0000_0040 | m);
        end
        v = $random(seed);
        bus(1'b1, `LBL_OFS_SEG1, v);
        bus(1'b1, `LBL_OFS_REF, 32'h0000_00EA);
        bus(1'b1, `LBL_OFS_CST, 32'h0000_0007);
        bus(1'b1, `LBL_OFS_LADDER, 32'h0000_00D3);
        settle;
        `LBL_CMP(seg[15:8], v[7:0])
        `LBL_CMP(seg_oe_n[15:8], ~v[7:0])
        `LBL_CMP({pwr, ref_on, cst_on}, 4'h0)
        `LBL_CMP({vpin, tap}, 6'h2F)
        @(posedge clk);
        run <= 1'b1;
        settle;
        `LBL_CMP({ref_on, cst_on, fvr_req, fvr_src}, 4'hF)
        @(posedge clk);
        rd_exp(`LBL_OFS_CTRL, 32'h0000_0063);
        $display("pin and reference test done");
        ab_run(3, 16);
        bus(1'b1, `LBL_OFS_CTRL, 32'h0000_00C3);
        ab_run(6, 32);
        bus(1'b1, `LBL_OFS_CTRL, 32'h0000_0043);
        ab_run(0, 16);
        close_out;
    end
endmodule
